// file: include/ssf_pkg.sv
/*
 Package for the synchronous serial frame engine: register offsets,
 field positions, reset values and enumerations.
 Assumes a single 10 MHz clock and a plain register port.
*/
// Function
// - independent receiver and transmitter, one shared divider
// - three lines per direction: data, clock, sync
// - start automatically, or on sync line event (receiver only)
// - two dma word channels, one per direction
// - stop bit: end on compare0 or compare1
// - separate frame formats for transmit and receive
// - start delay up to 255 bit periods
// - word length up to 32 bits
// - up to 16 words per start event
// - sync length up to 256 bit periods
// - msb first or lsb first per direction
// - sync data shifted out during start delay
// - idle data line level set by bit
// - frame period up to 512 per direction
package ssf_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIV = 8'h04;
   localparam logic [7:0] OFS_TX_CLOCK_MODE = 8'h18;
   localparam logic [7:0] OFS_TX_FRAME_MODE = 8'h1C;
   localparam logic [7:0] OFS_RX_CLOCK_MODE = 8'h10;
   localparam logic [7:0] OFS_RX_FRAME_MODE = 8'h14;
   localparam logic [7:0] OFS_RX_HOLD = 8'h20;
   localparam logic [7:0] OFS_TX_HOLD = 8'h24;
   localparam logic [7:0] OFS_TX_SYNC_HOLD = 8'h34;
   localparam logic [7:0] OFS_CMP0 = 8'h38;
   localparam logic [7:0] OFS_CMP1 = 8'h3C;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CM_START_LO = 8;   // start select [9:8]
   localparam int CM_STOP = 12;      // stop select
   localparam int CM_DLY_LO = 16;    // start delay [23:16]
   localparam int CM_PER_LO = 24;    // period/2-1 [31:24]
   localparam int FM_LEN_LO = 0;     // word length-1 [4:0]
   localparam int FM_IDLE = 5;       // idle line level
   localparam int FM_MSB_FIRST_SELECT = 7;       // msb first
   localparam int FM_NB_LO = 8;      // words-1 [11:8]
   localparam int FM_SLEN_LO = 16;   // sync length-1 [23:16]
   localparam int FM_SDEN = 23;      // sync data enable (tx)
   localparam int CT_RXEN = 0;
   localparam int CT_TXEN = 8;
   // ----------------------------------------------------------------
   // reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [11:0] RST_DIV = 12'h001;
   localparam logic [7:0] RST_CNT8 = 8'h00;
   // start selections
   localparam logic [1:0] ST_AUTO = 2'h0;
   localparam logic [1:0] ST_SYNC_RISE = 2'h1;
   localparam logic [1:0] ST_SYNC_FALL = 2'h2;
   localparam logic [1:0] ST_CMP0 = 2'h3;
   // direction state
   typedef enum logic [1:0] {SSF_IDLE, SSF_DELAY, SSF_DATA,
      SSF_GAP} ssf_phase_e;
endpackage

// file: rtl/ssf_engine.sv
/*
 Synchronous serial frame engine: one transmitter, one receiver and a
 shared clock divider, reached over a plain register port. Words move
 to and from two dma request channels.
 Assumes all inputs synchronous to mclk; the codec's side is master
 of nothing here - both bit clocks are made from the divider.
*/
`timescale 1ns/1ps
module ssf_engine (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // transmit lines
   output logic tx_serial_data,
   output logic tx_bit_clock,
   output logic tx_frame_sync,
   // receive lines
   input wire logic rx_serial_data,
   input wire logic rx_frame_sync,
   output logic rx_bit_clock,
   // dma channels
   output logic tx_dma_req,
   input wire logic tx_dma_ack,
   input wire logic [31:0] tx_dma_data,
   output logic rx_dma_req,
   input wire logic rx_dma_ack,
   output logic [31:0] rx_dma_data
);
   import ssf_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      ssf_phase_e ph;       // frame phase
      logic [7:0] dly;      // start delay counter
      logic [8:0] per;      // bit periods left in frame
      logic [4:0] bit_n;    // bits done in word
      logic [3:0] word_n;   // words done in frame
      logic [8:0] sync_n;   // sync bits left
      logic [31:0] sh;      // shift register
      logic [31:0] hold;    // holding register
      logic full;           // holding register valid
   } ssf_dir_s;

   typedef struct packed {
      logic [31:0] ctrl, div, tcm, tfm, rcm, rfm, tsh, cmp0, cmp1;
      logic [11:0] dcnt;    // shared divider counter
      logic bclk;           // shared bit clock
      ssf_dir_s tx, rx;
      logic rx_sync_d;      // previous receive sync level
      logic cmp_hit;        // compare started receiver
      logic [31:0] rdata;
      logic tsd, tfs, tdr, rdr;
      logic [31:0] rdd;
      logic ovr;            // receive overrun, sticky
   } ssf_state_s;

   ssf_state_s q, next_q;

   // event decode used by both directions
   function automatic logic start_hit(input logic [1:0] sel,
         input logic now, input logic prev);
      case (sel)
         ST_AUTO: start_hit = 1'b1;
         ST_SYNC_RISE: start_hit = now & ~prev;
         ST_SYNC_FALL: start_hit = ~now & prev;
         default: start_hit = 1'b0;
      endcase
   endfunction

   // picks the next bit of a word, in either order
   function automatic logic pick_bit(input logic [31:0] w,
         input logic [4:0] n, input logic [4:0] len, input logic msb_first_select);
      pick_bit = msb_first_select ? w[len - n] : w[n];
   endfunction

   logic fall;   // one cycle at a falling bit clock edge: shift here
   logic rise;   // one cycle at a rising edge: sample here
   logic [7:0] rx_cmp_byte;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_q = q;
      fall = 1'b0;
      rise = 1'b0;
      rx_cmp_byte = q.rx.sh[7:0];
      // shared divider feeds both directions
      if (q.div[11:0] != 12'h000) begin
         if (q.dcnt >= q.div[11:0] - 12'h001) begin
            next_q.dcnt = 12'h000;
            next_q.bclk = ~q.bclk;
            fall = q.bclk;
            rise = ~q.bclk;
         end else begin
            next_q.dcnt = q.dcnt + 12'h001;
         end
      end
      next_q.rx_sync_d = rx_frame_sync;

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            OFS_CTRL: next_q.ctrl = reg_wdata;
            OFS_DIV: next_q.div = reg_wdata;
            OFS_TX_CLOCK_MODE: next_q.tcm = reg_wdata;
            OFS_TX_FRAME_MODE: next_q.tfm = reg_wdata;
            OFS_RX_CLOCK_MODE: next_q.rcm = reg_wdata;
            OFS_RX_FRAME_MODE: next_q.rfm = reg_wdata;
            OFS_TX_SYNC_HOLD: next_q.tsh = reg_wdata;
            OFS_CMP0: next_q.cmp0 = reg_wdata;
            OFS_CMP1: next_q.cmp1 = reg_wdata;
            OFS_TX_HOLD: begin
               next_q.tx.hold = reg_wdata;
               next_q.tx.full = 1'b1;
            end
            default: ;
         endcase
      end
      // register reads, data one cycle later
      next_q.rdata = RST_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL: next_q.rdata = q.ctrl;
            OFS_DIV: next_q.rdata = q.div;
            OFS_TX_CLOCK_MODE: next_q.rdata = q.tcm;
            OFS_TX_FRAME_MODE: next_q.rdata = q.tfm;
            OFS_RX_CLOCK_MODE: next_q.rdata = q.rcm;
            OFS_RX_FRAME_MODE: next_q.rdata = q.rfm;
            OFS_TX_SYNC_HOLD: next_q.rdata = q.tsh;
            OFS_CMP0: next_q.rdata = q.cmp0;
            OFS_CMP1: next_q.rdata = q.cmp1;
            OFS_RX_HOLD: next_q.rdata = q.rx.hold;
            OFS_STATUS: next_q.rdata = {26'h0, q.ovr, q.cmp_hit,
               q.rx.full, q.tx.full, q.rx.ph != SSF_IDLE,
               q.tx.ph != SSF_IDLE};
            default: next_q.rdata = RST_ZERO;
         endcase
         if (reg_addr == OFS_RX_HOLD) begin
            next_q.rx.full = 1'b0;
         end
         if (reg_addr == OFS_STATUS) begin
            next_q.ovr = 1'b0;
         end
      end
      // dma feeds the transmit holding register
      if (tx_dma_ack && !q.tx.full) begin
         next_q.tx.hold = tx_dma_data;
         next_q.tx.full = 1'b1;
      end
      if (rx_dma_ack) begin
         next_q.rx.full = 1'b0;
      end

      // ---------------- transmitter, shifts on falling edge ----------
      if (!q.ctrl[CT_TXEN]) begin
         next_q.tx.ph = SSF_IDLE;
         next_q.tsd = q.tfm[FM_IDLE];
         next_q.tfs = 1'b0;
      end else if (fall) begin
         // frame period counter restarts frames
         if (q.tx.per != 9'h000) begin
            next_q.tx.per = q.tx.per - 9'h001;
         end
         if (q.tx.sync_n != 9'h000) begin
            next_q.tx.sync_n = q.tx.sync_n - 9'h001;
         end
         next_q.tfs = q.tx.sync_n != 9'h000;
         case (q.tx.ph)
            SSF_IDLE: begin
               next_q.tsd = q.tfm[FM_IDLE];
               if (q.tx.full && q.tx.per == 9'h000 &&
                     start_hit(q.tcm[CM_START_LO+:2], 1'b0, 1'b0)) begin
                  // start now, the sync line is driven, not watched
                  next_q.tx.ph = SSF_DELAY;
                  next_q.tx.dly = q.tcm[CM_DLY_LO+:8];
                  next_q.tx.per = {q.tcm[CM_PER_LO+:8], 1'b1};
                  next_q.tx.sync_n = {1'b0, q.tfm[FM_SLEN_LO+:8]}
                     + 9'h001;
                  next_q.tx.word_n = 4'h0;
                  next_q.tx.bit_n = 5'h00;
                  next_q.tfs = 1'b1;
               end
            end
            SSF_DELAY: begin
               // sync data goes out during the start delay
               next_q.tsd = q.tfm[FM_SDEN] ?
                  q.tsh[q.tx.sync_n[4:0]] : q.tfm[FM_IDLE];
               if (q.tx.dly != RST_CNT8) begin
                  next_q.tx.dly = q.tx.dly - 8'h01;
               end else if (q.tx.full) begin
                  next_q.tx.sh = q.tx.hold;
                  // a word written in this very cycle stays pending
                  next_q.tx.full = reg_wr && reg_addr == OFS_TX_HOLD;
                  next_q.tx.ph = SSF_DATA;
               end
            end
            SSF_DATA: begin
               // one bit per bit clock period
               next_q.tsd = pick_bit(q.tx.sh, q.tx.bit_n,
                  q.tfm[FM_LEN_LO+:5], q.tfm[FM_MSB_FIRST_SELECT]);
               next_q.tx.bit_n = q.tx.bit_n + 5'h01;
               if (q.tx.bit_n == q.tfm[FM_LEN_LO+:5]) begin
                  next_q.tx.bit_n = 5'h00;
                  next_q.tx.word_n = q.tx.word_n + 4'h1;
                  if (q.tx.word_n == q.tfm[FM_NB_LO+:4]) begin
                     next_q.tx.ph = SSF_IDLE;
                  end else if (q.tx.full) begin
                     next_q.tx.sh = q.tx.hold;
                     next_q.tx.full = reg_wr && reg_addr == OFS_TX_HOLD;
                  end else begin
                     next_q.tx.ph = SSF_IDLE;  // underrun ends frame
                  end
               end
            end
            default: next_q.tx.ph = SSF_IDLE;
         endcase
      end

      // ---------------- receiver, samples on rising edge -------------
      if (!q.ctrl[CT_RXEN]) begin
         next_q.rx.ph = SSF_IDLE;
         next_q.cmp_hit = 1'b0;
      end else if (rise) begin
         if (q.rx.per != 9'h000) begin
            next_q.rx.per = q.rx.per - 9'h001;
         end
         case (q.rx.ph)
            SSF_IDLE: begin
               if (q.rx.per == 9'h000 &&
                     (start_hit(q.rcm[CM_START_LO+:2], rx_frame_sync,
                      q.rx_sync_d) || q.cmp_hit)) begin
                  next_q.rx.ph = SSF_DELAY;
                  next_q.rx.dly = q.rcm[CM_DLY_LO+:8];
                  next_q.rx.per = {q.rcm[CM_PER_LO+:8], 1'b1};
                  next_q.rx.word_n = 4'h0;
                  next_q.rx.bit_n = 5'h00;
               end else if (q.rcm[CM_START_LO+:2] == ST_CMP0) begin
                  // compare mode listens bit by bit
                  next_q.rx.sh = {q.rx.sh[30:0], rx_serial_data};
               end
            end
            SSF_DELAY: begin
               if (q.rx.dly != RST_CNT8) begin
                  next_q.rx.dly = q.rx.dly - 8'h01;
               end else begin
                  next_q.rx.ph = SSF_GAP;
               end
            end
            SSF_GAP: begin
               // the transmitter spends one period loading its word,
               // so the first bit lands one period after the delay
               next_q.rx.ph = SSF_DATA;
               next_q.rx.sh = q.rfm[FM_MSB_FIRST_SELECT] ?
                  {31'h0, rx_serial_data} :
                  {rx_serial_data, 31'h0};
               next_q.rx.bit_n = 5'h01;
            end
            SSF_DATA: begin
               // sampling edge the same for every bit
               next_q.rx.sh = q.rfm[FM_MSB_FIRST_SELECT] ?
                  {q.rx.sh[30:0], rx_serial_data} :
                  {rx_serial_data, q.rx.sh[31:1]};
               next_q.rx.bit_n = q.rx.bit_n + 5'h01;
               if (q.rx.bit_n == q.rfm[FM_LEN_LO+:5] + 5'h01) begin
                  next_q.rx.hold = q.rfm[FM_MSB_FIRST_SELECT] ? q.rx.sh :
                     q.rx.sh >> (5'd31 - q.rfm[FM_LEN_LO+:5]);
                  next_q.ovr = next_q.ovr | next_q.rx.full;
                  next_q.rx.full = 1'b1;
                  next_q.rx.sh = q.rfm[FM_MSB_FIRST_SELECT] ?
                     {31'h0, rx_serial_data} :
                     {rx_serial_data, 31'h0};
                  next_q.rx.bit_n = 5'h01;
                  next_q.rx.word_n = q.rx.word_n + 4'h1;
                  if (q.rx.word_n == q.rfm[FM_NB_LO+:4]) begin
                     next_q.rx.ph = SSF_IDLE;
                  end
               end
            end
            default: next_q.rx.ph = SSF_IDLE;
         endcase
         // compare start and stop selection
         if (q.rcm[CM_START_LO+:2] == ST_CMP0) begin
            if (!q.cmp_hit && rx_cmp_byte == q.cmp0[7:0]) begin
               next_q.cmp_hit = 1'b1;
            end else if (q.cmp_hit && q.rcm[CM_STOP] &&
                  rx_cmp_byte == q.cmp1[7:0]) begin
               next_q.cmp_hit = 1'b0;
            end
         end
      end
      // a new compare 0 written ends reception when stop bit is clear
      if (reg_wr && reg_addr == OFS_CMP0 && !q.rcm[CM_STOP]) begin
         next_q.cmp_hit = 1'b0;
      end
      next_q.tdr = q.ctrl[CT_TXEN] & ~next_q.tx.full;
      next_q.rdr = next_q.rx.full;
      next_q.rdd = next_q.rx.hold;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.div <= {20'h0, RST_DIV};
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from flip-flops; both lines share one divider
   assign reg_rdata = q.rdata;
   assign tx_serial_data = q.tsd;
   assign tx_bit_clock = q.bclk;
   assign rx_bit_clock = q.bclk;
   assign tx_frame_sync = q.tfs;
   assign tx_dma_req = q.tdr;
   assign rx_dma_req = q.rdr;
   assign rx_dma_data = q.rdd;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_idle_level: assert property (@(posedge mclk) disable iff (!rstn)
      $past(!q.ctrl[CT_TXEN]) |-> tx_serial_data == $past(q.tfm[FM_IDLE]))
      else $error("idle level wrong");
   a_tx_disable: assert property (@(posedge mclk) disable iff (!rstn)
      !q.ctrl[CT_TXEN] |=> q.tx.ph == SSF_IDLE)
      else $error("tx not idle");
   a_clk_shared: assert property (@(posedge mclk) disable iff (!rstn)
      tx_bit_clock == rx_bit_clock) else $error("clocks differ");
   a_bit_step: assert property (@(posedge mclk) disable iff (!rstn)
      (q.tx.ph == SSF_DATA && !fall) |=> $stable(q.tx.bit_n))
      else $error("bit moved off edge");
   a_word_len: assert property (@(posedge mclk) disable iff (!rstn)
      q.tx.ph == SSF_DATA |-> q.tx.bit_n <= q.tfm[FM_LEN_LO+:5])
      else $error("word too long");
   a_word_count: assert property (@(posedge mclk) disable iff (!rstn)
      q.rx.ph == SSF_DATA |-> q.rx.word_n <= q.rfm[FM_NB_LO+:4])
      else $error("too many words");
   a_delay_hold: assert property (@(posedge mclk) disable iff (!rstn)
      (q.tx.ph == SSF_DELAY && q.tx.dly != RST_CNT8 && q.ctrl[CT_TXEN])
      |=> q.tx.ph == SSF_DELAY) else $error("delay skipped");
   a_dma_req: assert property (@(posedge mclk) disable iff (!rstn)
      rx_dma_req |-> rx_dma_data == q.rx.hold)
      else $error("dma data stale");
endmodule // ssf_engine

// file: testbench/ssf_codec_model.sv
/*
 Echoing codec model for the frame engine: hands the transmit lines
 back on the receive lines and records the transmit bits of a frame.
 Assumes the engine makes both bit clocks and all lines move on mclk.
*/
`timescale 1ns/1ps
module ssf_codec_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // lines from the engine
   input wire logic tx_serial_data,
   input wire logic tx_bit_clock,
   input wire logic tx_frame_sync,
   input wire logic rx_bit_clock,
   // lines to the engine
   output logic rx_serial_data,
   output logic rx_frame_sync,
   // frame capture for the bench
   input wire logic cap_clear,
   output logic [511:0] cap_bits,
   output logic [9:0] cap_cnt
);
   logic clk_prev; // bit clock level at last mclk edge
   logic sync_prev; // sync level at last bit clock rise
   logic armed; // waits for the first sync rise after a clear
   // ----------------------------------------------------------------
   // echo path
   // ----------------------------------------------------------------
   // plain wires, so receive framing can only follow transmit framing
   assign rx_serial_data = tx_serial_data;
   assign rx_frame_sync = tx_frame_sync;
   // ----------------------------------------------------------------
   // capture
   // ----------------------------------------------------------------
   // sample on bit clock rise, half a bit after the engine shifts
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         clk_prev <= 1'b0;
         sync_prev <= 1'b0;
         armed <= 1'b0;
         cap_cnt <= 10'h000;
         cap_bits <= 512'h0;
      end else begin
         clk_prev <= tx_bit_clock;
         if (cap_clear) begin
            // new frame wanted: forget the old one
            armed <= 1'b1;
            cap_cnt <= 10'h000;
            cap_bits <= 512'h0;
         end else if (tx_bit_clock && !clk_prev) begin
            sync_prev <= tx_frame_sync;
            if (armed && tx_frame_sync && !sync_prev) begin
               // frame starts with the sync rise
               armed <= 1'b0;
               cap_bits[0] <= tx_serial_data;
               cap_cnt <= 10'h001;
            end else if (cap_cnt != 10'h000 && cap_cnt < 10'h200) begin
               cap_bits[cap_cnt[8:0]] <= tx_serial_data;
               cap_cnt <= cap_cnt + 10'h001;
            end
         end
      end
   end
endmodule // ssf_codec_model

// file: testbench/ssf_engine_tb_top.sv
/*
 Self-checking bench for the frame engine: table of frame formats run
 through an echoing codec, then reset, register and line checks.
 Assumes the engine's register port and dma handshakes as handed over.
*/
`timescale 1ns/1ps
module ssf_engine_tb_top;
   import ssf_pkg::*;
   // one frame format and its words
   typedef struct {
      logic [4:0] len_m1;
      logic msb_first_select;
      logic idle;
      logic [3:0] nb_m1;
      logic [7:0] dly;
      logic [31:0] w0;
      logic [31:0] w1;
   } ssf_row_s;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic tx_serial_data, tx_bit_clock, tx_frame_sync;
   logic rx_serial_data, rx_frame_sync, rx_bit_clock;
   logic tx_dma_req, rx_dma_req;
   logic tx_dma_ack = 1'b0;
   logic rx_dma_ack = 1'b0;
   logic [31:0] tx_dma_data = 32'h0000_0000;
   logic [31:0] rx_dma_data;
   logic cap_clear = 1'b0;
   logic [511:0] cap_bits;
   logic [9:0] cap_cnt;
   logic [31:0] txq[$]; // words waiting for the transmit channel
   logic [31:0] rxq[$]; // words taken from the receive channel
   int tx_gap = 0;
   int rx_gap = 0;
   int error_cnt = 0;
   int n_tests = 0;
   logic [31:0] rd;
   // boundary formats: short, lsb first, full width, max delay
   ssf_row_s rows[4] = '{
      '{5'h07, 1'b1, 1'b0, 4'h0, 8'h00, 32'h0000_00A5, 32'h0},
      '{5'h07, 1'b0, 1'b1, 4'h0, 8'h03, 32'h0000_003C, 32'h0},
      '{5'h1F, 1'b1, 1'b0, 4'h0, 8'h01, 32'hC0DE_1234, 32'h0},
      '{5'h04, 1'b0, 1'b0, 4'h1, 8'hFF, 32'h0000_0013, 32'h0000_000A}};
   always #50 mclk = ~mclk;
   ssf_engine u_ssf_engine (.mclk, .rstn, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .tx_serial_data, .tx_bit_clock,
      .tx_frame_sync, .rx_serial_data, .rx_frame_sync, .rx_bit_clock,
      .tx_dma_req, .tx_dma_ack, .tx_dma_data, .rx_dma_req, .rx_dma_ack,
      .rx_dma_data);
   ssf_codec_model u_ssf_codec_model (.mclk, .rstn, .tx_serial_data,
      .tx_bit_clock, .tx_frame_sync, .rx_bit_clock, .rx_serial_data,
      .rx_frame_sync, .cap_clear, .cap_bits, .cap_cnt);
   // ----------------------------------------------------------------
   // dma channels
   // ----------------------------------------------------------------
   // one-cycle ack, then a pause so a lagging request is not taken twice
   always @(posedge mclk) begin
      if (tx_dma_ack) begin
         tx_dma_ack <= 1'b0;
         tx_gap <= 2;
      end else if (tx_gap > 0) begin
         tx_gap <= tx_gap - 1;
      end else if (tx_dma_req && txq.size() > 0) begin
         tx_dma_ack <= 1'b1;
         tx_dma_data <= txq.pop_front();
      end
      if (rx_dma_ack) begin
         // word is taken at the edge that sees the ack
         rxq.push_back(rx_dma_data);
         rx_dma_ack <= 1'b0;
         rx_gap <= 2;
      end else if (rx_gap > 0) begin
         rx_gap <= rx_gap - 1;
      end else if (rx_dma_req) begin
         rx_dma_ack <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, e, s);
      end
   endtask
   // a used-up bound ends the run at once
   task automatic bound(input int t, input int lim);
      if (t >= lim) begin
         check("wait", 32'h1, 32'h0);
         test_done();
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check("read data", e, reg_rdata);
      @(posedge mclk);
      #1 check("read after", 32'h0, reg_rdata);
   endtask
   task automatic new_frame();
      @(posedge mclk);
      cap_clear <= 1'b1;
      @(posedge mclk);
      cap_clear <= 1'b0;
   endtask
   function automatic logic exp_bit(input ssf_row_s r, input int k);
      int n;
      int b;
      n = r.len_m1 + 1;
      b = k % n;
      if (r.msb_first_select) b = n - 1 - b;
      return (k < n) ? r.w0[b] : r.w1[b];
   endfunction
   // one frame out through the echo and back in
   task automatic run_frame(input ssf_row_s r);
      int n;
      int t;
      int hp;
      logic ok;
      n = (r.len_m1 + 1) * (r.nb_m1 + 1);
      hp = -1;
      txq.push_back(r.w0);
      if (r.nb_m1 != 4'h0) txq.push_back(r.w1);
      reg_write(OFS_TX_CLOCK_MODE, {8'hFF, r.dly, 6'h00, ST_AUTO, 8'h00});
      reg_write(OFS_RX_CLOCK_MODE,
                {8'hFF, r.dly, 6'h00, ST_SYNC_RISE, 8'h00});
      reg_write(OFS_TX_FRAME_MODE, {16'h0000, 4'h0, r.nb_m1, r.msb_first_select, 1'b0,
                r.idle, r.len_m1});
      reg_write(OFS_RX_FRAME_MODE, {16'h0000, 4'h0, r.nb_m1, r.msb_first_select, 1'b0,
                r.idle, r.len_m1});
      new_frame();
      reg_write(OFS_CTRL, 32'h0000_0101);
      for (t = 0; t < 6000 && cap_cnt < 10'(r.dly + 5 + n); t++) begin
         @(posedge mclk);
      end
      bound(t, 6000);
      // allow a few bits of slack for where the start event is counted
      for (int p = r.dly; p < r.dly + 4; p++) begin
         ok = 1'b1;
         for (int k = 0; k < n; k++) begin
            if (cap_bits[p + k] !== exp_bit(r, k)) ok = 1'b0;
         end
         if (ok && hp < 0) hp = p;
      end
      check("tx bit stream", 32'h1, 32'(hp >= 0));
      if (hp >= 0) check("idle after", 32'(r.idle), 32'(cap_bits[hp + n]));
      for (t = 0; t < 3000 && rxq.size() < r.nb_m1 + 1; t++) begin
         @(posedge mclk);
      end
      bound(t, 3000);
      check("rx word 0", r.w0 & (32'hFFFF_FFFF >> (31 - r.len_m1)),
            rxq[0]);
      if (r.nb_m1 != 4'h0) check("rx word 1",
            r.w1 & (32'hFFFF_FFFF >> (31 - r.len_m1)), rxq[1]);
      reg_write(OFS_CTRL, 32'h0000_0000);
      repeat (20) @(posedge mclk);
      rxq.delete();
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int t;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      foreach (rows[i]) run_frame(rows[i]);
      // second reset mid-run, settings left behind must be cleared
      reg_write(OFS_TX_FRAME_MODE, 32'h0000_0020);
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (8) @(posedge mclk);
      check("sync in reset", 32'h0, 32'(tx_frame_sync));
      rstn <= 1'b1;
      rd_chk(OFS_CTRL, 32'h0000_0000);
      rd_chk(OFS_DIV, 32'h0000_0001);
      rd_chk(OFS_TX_FRAME_MODE, 32'h0000_0000);
      rd_chk(OFS_RX_CLOCK_MODE, 32'h0000_0000);
      rd_chk(OFS_STATUS, 32'h0000_0000);
      // readback, back-to-back writes, and an unmapped place
      reg_write(OFS_DIV, 32'h0000_0002);
      reg_write(8'h08, 32'hFFFF_FFFF);
      rd_chk(OFS_DIV, 32'h0000_0002);
      rd_chk(8'h08, 32'h0000_0000);
      reg_write(OFS_RX_CLOCK_MODE, 32'h1234_1200);
      rd_chk(OFS_RX_CLOCK_MODE, 32'h1234_1200);
      // idle level with nothing to send, receiver left off
      reg_write(OFS_TX_FRAME_MODE, 32'h0000_0027);
      reg_write(OFS_CTRL, 32'h0000_0100);
      repeat (10) @(posedge mclk);
      check("idle line", 32'h1, 32'(tx_serial_data));
      check("rx request", 32'h0, 32'(rx_dma_req));
      // compare start on a matching byte, stopped by a new compare 0
      reg_write(OFS_CMP0, 32'h0000_00FF);
      reg_write(OFS_RX_CLOCK_MODE, 32'h0000_0300);
      reg_write(OFS_CTRL, 32'h0000_0101);
      repeat (60) @(posedge mclk);
      check("compare hit", 32'h1, 32'(u_ssf_engine.q.cmp_hit));
      reg_write(OFS_CMP0, 32'h0000_0000);
      #1 check("compare stop", 32'h0, 32'(u_ssf_engine.q.cmp_hit));
      // sync data: all ones shown where idle would give zeros
      reg_write(OFS_CTRL, 32'h0000_0000);
      reg_write(OFS_TX_SYNC_HOLD, 32'hFFFF_FFFF);
      reg_write(OFS_TX_CLOCK_MODE, 32'hFF10_0000);
      reg_write(OFS_TX_FRAME_MODE, 32'h0087_0087);
      txq.push_back(32'h0000_0000);
      new_frame();
      reg_write(OFS_CTRL, 32'h0000_0100);
      for (t = 0; t < 6000 && cap_cnt < 10'h008; t++) begin
         @(posedge mclk);
      end
      bound(t, 6000);
      check("sync data", 32'h3F, 32'(cap_bits[6:1]));
      test_done();
   end
endmodule // ssf_engine_tb_top
